/* File: bpm_core.sv */
`timescale 1ns/1ns

//----------------------------------------------------------------------
// flip-flop fifo
//----------------------------------------------------------------------
// storage is plain registers addressed by index; depth must be a power
// of two so the pointers wrap by themselves
module bpm_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // draining side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // refuse shapes the pointer arithmetic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("bpm_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    // honest flags from the occupancy count
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    // pointers and occupancy
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset; empty entries are never presented
    always_ff @(posedge ref_clk_i) begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end
endmodule

//----------------------------------------------------------------------
// device side byte placement and write masking
//----------------------------------------------------------------------
// the bus clock pin is sampled by ref_clk_i, so it must run well below
// a quarter of the local rate; both of its edges become one-cycle
// events from the second local clock edge after the pin moved
module bpm_core #(
    parameter int FIFO_DEPTH = bpm_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // bus pins
    input  wire logic                  bus_clock_true_i,
    input  wire logic                  chip_sel_n_i,
    input  wire logic [7:0]            dq_i,
    output logic      [7:0]            dq_o,
    output logic                       dq_oe_o,
    input  wire logic                  data_strobe_mask_i,
    output logic                       data_strobe_mask_o,
    output logic                       data_strobe_mask_oe_o,
    // transaction phase from the command logic
    input  wire logic                  rd_phase_i,
    input  wire logic                  wr_phase_i,
    input  wire logic                  zero_latency_i,
    // register words to send
    input  wire logic                  rd_valid_i,
    input  wire logic [15:0]           rd_word_i,
    output logic                       rd_ready_o,
    // captured words out
    output logic                       wr_valid_o,
    output bpm_pkg::bpm_wword_type     wr_word_o,
    input  wire logic                  wr_ready_i,
    output logic                       wr_overflow_o
);
    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    bpm_pkg::bpm_pins_type pin_meta;
    bpm_pkg::bpm_pins_type pin_sync;
    logic                  clk_prev;

    // first stage feeds only the second
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= '{clk: 1'b0, cs_n: 1'b1, strobe: 1'b0,
                          dq: bpm_pkg::RST_BYTE};
            pin_sync <= '{clk: 1'b0, cs_n: 1'b1, strobe: 1'b0,
                          dq: bpm_pkg::RST_BYTE};
            clk_prev <= 1'b0;
        end else begin
            pin_meta <= '{clk: bus_clock_true_i, cs_n: chip_sel_n_i,
                          strobe: data_strobe_mask_i, dq: dq_i};
            pin_sync <= pin_meta;
            clk_prev <= pin_sync.clk;
        end
    end

    //------------------------------------------------------------------
    // edge events
    //------------------------------------------------------------------
    wire sel      = !pin_sync.cs_n;
    wire rise     = pin_sync.clk && !clk_prev;
    wire fall     = !pin_sync.clk && clk_prev;
    wire rd_act   = sel && rd_phase_i;
    wire wr_act   = sel && wr_phase_i && !rd_phase_i;
    wire rd_rise  = rd_act && rise;
    wire rd_fall  = rd_act && fall;
    wire wr_rise  = wr_act && rise;
    wire wr_fall  = wr_act && fall;

    //------------------------------------------------------------------
    // read path
    //------------------------------------------------------------------
    logic [7:0] rd_low;      // second byte waits for the falling edge
    logic [7:0] dq_out;
    logic       strobe_out;
    logic       rd_drive;

    // one word taken per bus clock, at its rising edge
    assign rd_ready_o = rd_rise;

    // a missing word shows as zero rather than stale bytes
    wire [15:0] rd_word = rd_valid_i ? rd_word_i : bpm_pkg::RST_WORD;

    // high byte with strobe high, low byte with strobe low; data and
    // strobe leave the same flop so they stay edge aligned
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_out     <= bpm_pkg::RST_BYTE;
            rd_low     <= bpm_pkg::RST_BYTE;
            strobe_out <= 1'b0;
            rd_drive   <= 1'b0;
        end else if (!rd_act) begin
            strobe_out <= 1'b0;
            rd_drive   <= 1'b0;
        end else if (rd_rise) begin
            dq_out     <= rd_word[bpm_pkg::HI_LSB +: 8];
            rd_low     <= rd_word[bpm_pkg::LO_LSB +: 8];
            strobe_out <= 1'b1;
            rd_drive   <= 1'b1;
        end else if (rd_fall) begin
            dq_out     <= rd_low;
            strobe_out <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // pin drive
    //------------------------------------------------------------------
    // a zero latency write gets a low strobe from us, since the host
    // leaves it free; a masked write hands the strobe to the host
    wire zl_drive = wr_act && zero_latency_i;

    assign dq_o                  = dq_out;
    assign dq_oe_o               = rd_drive;
    assign data_strobe_mask_o    = strobe_out;
    assign data_strobe_mask_oe_o = rd_drive || zl_drive;

    //------------------------------------------------------------------
    // write capture
    //------------------------------------------------------------------
    logic [7:0] cap_hi;
    logic       cap_mask_hi;
    logic       have_hi;     // first byte of the word already taken

    // first byte on the rising edge; host centers data so the sampled
    // level is settled by the time the edge is seen
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_hi      <= bpm_pkg::RST_BYTE;
            cap_mask_hi <= 1'b0;
            have_hi     <= 1'b0;
        end else if (!wr_act) begin
            have_hi     <= 1'b0;                          // frame ended
        end else if (wr_rise) begin
            cap_hi      <= pin_sync.dq;
            cap_mask_hi <= pin_sync.strobe;
            have_hi     <= 1'b1;
        end else if (wr_fall) begin
            have_hi     <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // word assembly
    //------------------------------------------------------------------
    // second byte joins on the falling edge; a high strobe sample
    // clears that byte's enable, zero latency enables both
    wire       word_done = wr_fall && have_hi;
    wire [1:0] mask_be   = {!cap_mask_hi, !pin_sync.strobe};
    wire [1:0] word_be   = zero_latency_i ? bpm_pkg::BE_ALL
                                          : mask_be;

    bpm_pkg::bpm_wword_type push_word;
    assign push_word.data = {cap_hi, pin_sync.dq};
    assign push_word.be   = word_be;

    //------------------------------------------------------------------
    // write buffer
    //------------------------------------------------------------------
    // the bus cannot be paused mid burst, so a word that meets a full
    // buffer is dropped and flagged instead of stalling the link
    logic fifo_in_ready;
    logic overflow;

    bpm_fifo #(
        .WIDTH ($bits(bpm_pkg::bpm_wword_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (word_done),
        .in_data_i   (push_word),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (wr_valid_o),
        .out_data_o  (wr_word_o),
        .out_ready_i (wr_ready_i)
    );

    // one-cycle pulse per lost word
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            overflow <= 1'b0;
        else
            overflow <= word_done && !fifo_in_ready;
    end

    assign wr_overflow_o = overflow;
endmodule

/* File: bpm_pkg.sv */
//----------------------------------------------------------------------
// byte placement for the octal ddr data lines
//----------------------------------------------------------------------
// Summary of operation
// - register word high byte first, then low byte
// - read sends two bytes per bus clock
// - read high byte while strobe high, edge aligned
// - write high byte on rise, low on fall
// - register words are always big endian
// - latency writes use strobe as byte mask
// - zero latency writes store whole words
// - device drives strobe low on zero latency writes
// - strobe high skips byte, low stores it
package bpm_pkg;

    //------------------------------------------------------------------
    // word layout on the data lines
    //------------------------------------------------------------------
    localparam int BYTE_W      = 8;
    localparam int WORD_W      = 16;
    localparam int HI_LSB      = 8;   // word[15:8] is the first byte
    localparam int LO_LSB      = 0;   // word[7:0] is the second byte
    localparam int BE_HI       = 1;   // enable bit of the first byte
    localparam int BE_LO       = 0;   // enable bit of the second byte
    localparam int FIFO_DEPTH  = 16;

    //------------------------------------------------------------------
    // values after reset, and the all-bytes enable
    //------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [1:0]  BE_ALL    = 2'h3;
    localparam logic [1:0]  SYNC_RST  = 2'h0;

    // one written word with its byte enables
    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  be;
    } bpm_wword_type;

    // pin levels after the synchronisers
    typedef struct packed {
        logic       clk;
        logic       cs_n;
        logic       strobe;
        logic [7:0] dq;
    } bpm_pins_type;

endpackage

/* File: bpm_core_properties.sv */
`timescale 1ns/1ns
//------
// port checks
//------
module bpm_core_chk #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    // read side
    input wire logic                   rd_phase_i,
    input wire logic                   rd_valid_i,
    input wire logic [15:0]            rd_word_i,
    input wire logic                   rd_ready_o,
    input wire logic [7:0]             dq_o,
    input wire logic                   dq_oe_o,
    input wire logic                   data_strobe_mask_o,
    input wire logic                   data_strobe_mask_oe_o,
    // write side
    input wire bpm_pkg::bpm_wword_type wr_word_o,
    input wire logic                   wr_valid_o,
    input wire logic                   wr_ready_i
);
    logic [15:0] taken;

    // word owed to the host; a refused word goes out as zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            taken <= 16'h0000;
        end else if (rd_ready_o) begin
            taken <= rd_valid_i ? rd_word_i : 16'h0000;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_rise_strobe: assert property (
        rd_ready_o |=> data_strobe_mask_o && dq_oe_o)
        else $error("strobe late");
    chk_high_byte: assert property (
        $rose(data_strobe_mask_o) |-> dq_o == taken[15:8])
        else $error("bad high byte");
    chk_low_byte: assert property (
        dq_oe_o && $fell(data_strobe_mask_o) |-> dq_o == taken[7:0])
        else $error("bad low byte");
    chk_dq_aligned: assert property (
        dq_oe_o && $past(dq_oe_o) && $stable(data_strobe_mask_o)
        |-> $stable(dq_o))
        else $error("data off strobe edge");
    chk_ready_pulse: assert property (
        rd_ready_o |-> !data_strobe_mask_o ##1 !rd_ready_o)
        else $error("bad take pulse");
    chk_oe_release: assert property (
        !rd_phase_i |=> !dq_oe_o)
        else $error("data driven outside read");
    chk_zero_lat_low: assert property (
        data_strobe_mask_oe_o && !dq_oe_o |-> !data_strobe_mask_o)
        else $error("strobe driven high");
    chk_drain_hold: assert property (
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o))
        else $error("head word moved");
endmodule

bind bpm_core bpm_core_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rd_phase_i(rd_phase_i),
    .rd_valid_i(rd_valid_i), .rd_word_i(rd_word_i), .rd_ready_o(rd_ready_o),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .data_strobe_mask_o(data_strobe_mask_o),
    .data_strobe_mask_oe_o(data_strobe_mask_oe_o), .wr_word_o(wr_word_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i)
);

/* File: bpm_host.sv */
`timescale 1ns/1ns
//------
// host controller model
//------
module bpm_host (
    // pins toward the device
    output logic       bclk_o,
    output logic       cs_n_o,
    output logic [7:0] dq_o,
    output logic       dq_oe_o,
    output logic       mask_o,
    output logic       mask_oe_o
);
    // idle bus: clock parked low, nothing selected or driven
    initial begin
        {bclk_o, dq_oe_o, mask_o, mask_oe_o} = 4'h0;
        cs_n_o = 1'b1;
        dq_o = 8'h00;
    end

    // a latency write parks the mask low first as its preamble
    task automatic open_tx(input logic wr, input logic zl);
        cs_n_o = 1'b0;
        dq_oe_o = wr;
        mask_oe_o = wr && !zl;
        mask_o = 1'b0;
        #400;
    endtask

    // one word per bus clock, each byte centred on its edge
    task automatic send(input logic [15:0] w, input logic [1:0] m);
        dq_o = w[15:8];
        mask_o = m[1];
        #200 bclk_o = 1'b1;
        #200 dq_o = w[7:0];
        mask_o = m[0];
        #200 bclk_o = 1'b0;
        #200;
    endtask

    // release lines, then deselect with the clock idle
    task automatic close_tx;
        dq_oe_o = 1'b0;
        mask_oe_o = 1'b0;
        #400 cs_n_o = 1'b1;
        #400;
    endtask
endmodule

/* File: bpm_core_tb.sv */
`timescale 1ns/1ns
//------
// bench for the byte placement core
//------
module bpm_core_tb;
    logic                   ref_clk_i, rst_n_i, wr_ready_i, rd_valid_i;
    logic                   rd_phase_i, wr_phase_i, zero_latency_i;
    logic                   bclk, cs_n, h_doe, h_m, h_moe, strobe_w, flt;
    logic                   dq_oe_o, data_strobe_mask_o, data_strobe_mask_oe_o;
    logic                   rd_ready_o, wr_valid_o, wr_overflow_o;
    logic                   prev_s, hold, new_rd;
    logic [7:0]             dq_o, h_dq, dq_w, hi;
    logic [15:0]            rd_word_i, rexp;
    bpm_pkg::bpm_wword_type wr_word_o;
    bpm_pkg::bpm_wword_type exp_wr[$];
    logic [15:0]            exp_rd[$];
    int                     miscompares, num_checks, ovf, i, nrd;

    // a released line shows a pattern that moves every cycle
    assign dq_w = dq_oe_o ? dq_o : (h_doe ? h_dq : {8{flt}});
    assign strobe_w = data_strobe_mask_oe_o ? data_strobe_mask_o
                                            : (h_moe ? h_m : flt);
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) flt <= ~flt;

    bpm_host host (
        .bclk_o(bclk), .cs_n_o(cs_n), .dq_o(h_dq), .dq_oe_o(h_doe),
        .mask_o(h_m), .mask_oe_o(h_moe)
    );
    bpm_core uut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_clock_true_i(bclk),
        .chip_sel_n_i(cs_n), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
        .data_strobe_mask_i(strobe_w),
        .data_strobe_mask_o(data_strobe_mask_o),
        .data_strobe_mask_oe_o(data_strobe_mask_oe_o),
        .rd_phase_i(rd_phase_i), .wr_phase_i(wr_phase_i),
        .zero_latency_i(zero_latency_i), .rd_valid_i(rd_valid_i),
        .rd_word_i(rd_word_i), .rd_ready_o(rd_ready_o),
        .wr_valid_o(wr_valid_o), .wr_word_o(wr_word_o),
        .wr_ready_i(wr_ready_i), .wr_overflow_o(wr_overflow_o)
    );

    task automatic cmp(input logic [17:0] seen, input logic [17:0] exp,
                       input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tx(input logic rd, input logic zl);
        rd_phase_i = rd;
        wr_phase_i = !rd;
        zero_latency_i = zl;
        host.open_tx(!rd, zl);
    endtask

    task automatic tx_end;
        host.close_tx();
        rd_phase_i = 1'b0;
        wr_phase_i = 1'b0;
        // let an edge pass so the next phase is not set in the same step
        @(negedge ref_clk_i);
    endtask

    // a dropped word is sent but not expected back
    task automatic wr(input logic [15:0] w, input logic [1:0] m,
                      input bit keep);
        logic [1:0] be;
        be = zero_latency_i ? 2'h3 : ~m;
        // device holds the strobe low only on zero latency writes
        cmp(18'({data_strobe_mask_oe_o, data_strobe_mask_o}),
            18'({zero_latency_i, 1'b0}), "strobe drive");
        if (keep) exp_wr.push_back({w, be});
        host.send(w, m);
    endtask

    // drain with stalls, feed read words, compare both streams
    always @(negedge ref_clk_i) begin
        wr_ready_i = hold ? 1'b0 : 1'($urandom);
        if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
            cmp(wr_word_o, exp_wr.pop_front(), "word");
        end
        if (dq_oe_o === 1'b1 && data_strobe_mask_o !== prev_s) begin
            if (data_strobe_mask_o === 1'b1) begin
                hi = dq_o;
                rexp = exp_rd.pop_front();
            end else begin
                nrd++;
                cmp({1'b0, data_strobe_mask_oe_o, hi, dq_o},
                    {2'h1, rexp}, "read");
            end
        end
        prev_s = data_strobe_mask_o;
        if (new_rd) begin
            rd_word_i = 16'($urandom);
            rd_valid_i = 1'($urandom);
        end
        new_rd = (rd_ready_o === 1'b1);
        if (new_rd) exp_rd.push_back(rd_valid_i ? rd_word_i : 16'h0000);
        if (wr_overflow_o === 1'b1) ovf++;
    end

    // reset, then masked, unmasked, read and overflow traffic
    initial begin
        void'($urandom(32'h4C3F));
        {ref_clk_i, flt, rst_n_i, rd_phase_i, wr_phase_i} = 5'h00;
        {zero_latency_i, hold, new_rd, prev_s, wr_ready_i} = 5'h00;
        rd_valid_i = 1'b1;
        rd_word_i = 16'($urandom);
        repeat (16) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        tx(1'b0, 1'b0);
        for (i = 0; i < 4; i++) wr(16'($urandom), 2'(i), 1'b1);
        tx_end();
        tx(1'b0, 1'b1);
        repeat (3) wr(16'($urandom), 2'($urandom), 1'b1);
        tx_end();
        tx(1'b1, 1'b0);
        repeat (5) host.send(16'h0000, 2'h0);
        tx_end();
        while (exp_wr.size() != 0) @(negedge ref_clk_i);
        hold = 1'b1;
        tx(1'b0, 1'b0);
        for (i = 0; i <= bpm_pkg::FIFO_DEPTH; i++) begin
            wr(16'($urandom), 2'($urandom), i < bpm_pkg::FIFO_DEPTH);
        end
        tx_end();
        cmp(18'(ovf), 18'h00001, "overflow");
        hold = 1'b0;
        while (exp_wr.size() != 0) @(negedge ref_clk_i);
        repeat (8) @(negedge ref_clk_i);
        cmp(18'(nrd), 18'h00005, "read words");
        stop_test();
    end

    // the run needs under 1000 cycles; a hang ends it as a failure
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        miscompares++;
        stop_test();
    end
endmodule
